// *** pkg/ulsf_pkg.sv ***
// Package for the receive line status flags block: bit positions, reset values, carrier types.
// Assumes a single 100 MHz core clock domain.
package ulsf_pkg;
  localparam int ULSF_DATA_W = 8;
  localparam int ULSF_FIFO_DEPTH = 128;
  localparam int ULSF_BIT_DR = 0;
  localparam int ULSF_BIT_OE = 1;
  localparam int ULSF_BIT_PE = 2;
  localparam int ULSF_BIT_FE = 3;
  localparam int ULSF_BIT_BI = 4;
  localparam int ULSF_BIT_FERR = 7;
  localparam logic [7:0] ULSF_LINE_STATUS_RST = 8'h00;

  // One received character as it leaves the receive shift register.
  typedef struct packed {
    logic [7:0] data;
    logic framing_err;
    logic parity_err;
    logic break_ind;
  } ulsf_char_t;
endpackage : ulsf_pkg

// *** design/ulsf_rx_status.sv ***
// Receive FIFO or holding register with per-character error flags and the line status byte.
// Assumes the receiver shift logic and host bus logic run on core_clk.
`timescale 1ns/1ps
module ulsf_rx_status
  import ulsf_pkg::*;
#(
  parameter int DEPTH = ULSF_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration.
  input wire logic fifo_enable,
  // Receiver side.
  input wire logic rx_char_valid,
  input wire ulsf_char_t rx_char,
  // Host side.
  input wire logic rbr_read,
  input wire logic status_read,
  output logic [7:0] rx_data,
  output logic [7:0] line_status,
  output logic [$clog2(DEPTH+1)-1:0] rx_level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // Refuse depths that the wrapping pointers cannot serve, and any character width but 8.
  if (DEPTH < 2) begin : g_depth_min
    $error("DEPTH must be at least 2");
  end
  if ((1 << AW) != DEPTH) begin : g_depth_pow2
    $error("DEPTH must be a power of two");
  end
  if (ULSF_DATA_W != 8) begin : g_data_w
    $error("Character width must be 8 bits");
  end

  // All state but the character storage: pointers, fill level, error count, overrun flag and the shift register copy.
  typedef struct packed {
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] err_count;
    logic overrun;
    ulsf_char_t shift_hold;
  } ulsf_state_t;

  ulsf_state_t st_r;
  ulsf_state_t st_nxt;

  // Character storage; one entry serves as the holding register when the FIFO is off.
  ulsf_char_t mem [DEPTH];

  // True when a character carries a parity, framing or break error.
  function automatic logic char_bad(
    input ulsf_char_t c
  );
    char_bad = c.framing_err | c.parity_err | c.break_ind;
  endfunction : char_bad

  // Moves a pointer on by one when enabled; the power of two depth makes it wrap by itself.
  function automatic logic [AW-1:0] ptr_step(
    input logic [AW-1:0] p,
    input logic en
  );
    if (en) begin
      ptr_step = p + AW'(1);
    end else begin
      ptr_step = p;
    end
  endfunction : ptr_step

  // Moves a counter up and down by one each; both together leave it unchanged.
  function automatic logic [CW-1:0] count_step(
    input logic [CW-1:0] c,
    input logic up,
    input logic down
  );
    logic [CW-1:0] r;
    r = c;
    if (up) begin
      r = r + CW'(1);
    end
    if (down) begin
      r = r - CW'(1);
    end
    count_step = r;
  endfunction : count_step

  // Assembles the status byte from the head character and the held flags.
  function automatic logic [7:0] status_byte(
    input ulsf_char_t h,
    input logic held,
    input logic ovr,
    input logic ferr
  );
    logic [7:0] s;
    s = ULSF_LINE_STATUS_RST;
    s[ULSF_BIT_DR] = held;
    s[ULSF_BIT_OE] = ovr;
    if (held) begin
      s[ULSF_BIT_PE] = h.parity_err;
      s[ULSF_BIT_FE] = h.framing_err;
      s[ULSF_BIT_BI] = h.break_ind;
    end
    s[ULSF_BIT_FERR] = ferr;
    status_byte = s;
  endfunction : status_byte

  logic [CW-1:0] cap;
  logic full;
  logic have;
  logic push;
  logic pop;
  logic lost;
  logic bad_in;
  logic bad_out;
  logic fifo_err;
  ulsf_char_t head;

  // Room is the whole FIFO in FIFO mode and a single holding register otherwise.
  always_comb begin
    if (fifo_enable) begin
      cap = CW'(DEPTH);
    end else begin
      cap = CW'(1);
    end
  end

  // Occupancy flags from the registered fill level.
  always_comb begin
    full = (st_r.count >= cap);
    have = (st_r.count != '0);
  end

  // A character is stored only while there is room; otherwise it is lost to overrun.
  always_comb begin
    push = rx_char_valid && !full;
    lost = rx_char_valid && full;
    pop = rbr_read && have;
  end

  // The head entry is the oldest character still held.
  always_comb begin
    head = mem[st_r.rd_ptr];
    bad_in = push && char_bad(rx_char);
    bad_out = pop && char_bad(head);
  end

  // Storage write port; the stored characters are never touched on overrun.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st_r.wr_ptr] <= rx_char;
    end
  end

  // Next state.
  always_comb begin
    st_nxt = st_r;

    // Pointers and fill level.
    st_nxt.wr_ptr = ptr_step(st_r.wr_ptr, push);
    st_nxt.rd_ptr = ptr_step(st_r.rd_ptr, pop);
    st_nxt.count = count_step(st_r.count, push, pop);

    // Number of stored characters that carry an error.
    st_nxt.err_count = count_step(st_r.err_count, bad_in, bad_out);

    // Overrun: a new event wins over a clear by a status read in the same cycle.
    if (lost) begin
      st_nxt.shift_hold = rx_char;
    end
    if (status_read) begin
      st_nxt.overrun = 1'b0;
    end
    if (lost) begin
      st_nxt.overrun = 1'b1;
    end

    // Keep the holding register aligned when the FIFO is off and empty and no overrun is pending.
    if (!fifo_enable && !st_r.overrun && !have && st_r.rd_ptr != st_r.wr_ptr) begin
      st_nxt.rd_ptr = st_r.wr_ptr;
    end
  end

  // State register; reset clears every flag and empties the storage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The summary error flag only has meaning in FIFO mode.
  always_comb begin
    fifo_err = fifo_enable && (st_r.err_count != '0);
  end

  // Head character data, zero while nothing is held.
  always_comb begin
    if (have) begin
      rx_data = head.data;
    end else begin
      rx_data = 8'h00;
    end
  end

  // Fill level straight from the counter.
  always_comb begin
    rx_level = st_r.count;
  end

  // Line status byte; bits 5 and 6 belong to the transmitter and read 0 here.
  always_comb begin
    line_status = status_byte(head, have, st_r.overrun, fifo_err);
  end
endmodule : ulsf_rx_status

// *** bench/ulsf_host.sv ***
// Host model: issues one-cycle read strobes. Assumes core_clk from the bench.
`timescale 1ns/1ps
module ulsf_host (
  // Clock.
  input wire logic core_clk,
  // Read strobes.
  output logic rbr_read,
  output logic status_read
);
  initial {rbr_read, status_read} = 2'h0;
  task rd(input logic st);
    @(posedge core_clk);
    if (st) begin
      status_read <= 1'b1;
    end else begin
      rbr_read <= 1'b1;
    end
    @(posedge core_clk);
    {rbr_read, status_read} <= 2'h0;
    #1;
  endtask : rd
endmodule : ulsf_host

// *** bench/ulsf_rx_status_sva.sv ***
// Checker on the status block ports. Assumes one clock domain.
`timescale 1ns/1ps
module ulsf_rx_status_chk
  import ulsf_pkg::*;
#(parameter int DEPTH = 4) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fifo_enable,
  input wire logic rx_char_valid,
  input wire logic rbr_read,
  input wire logic status_read,
  input wire ulsf_char_t rx_char,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] line_status,
  input wire logic [$clog2(DEPTH+1)-1:0] rx_level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  fe_set_a: assert property (rx_char_valid && rx_level == 0 && !rbr_read |=>
    line_status[3] == $past(rx_char.framing_err)) else $error("framing flag");
  pe_set_a: assert property (rx_char_valid && rx_level == 0 && !rbr_read |=>
    line_status[2] == $past(rx_char.parity_err)) else $error("parity flag");
  head_hold_a: assert property (rx_level != 0 && !rbr_read |=> $stable(line_status[3:2]))
    else $error("head flags moved");
  oe_set_a: assert property (fifo_enable && rx_char_valid && rx_level == DEPTH |=> line_status[1])
    else $error("overrun not set");
  full_keep_a: assert property (fifo_enable && rx_level == DEPTH && !rbr_read |=> rx_level == DEPTH)
    else $error("full level moved");
  dr_flag_a: assert property (line_status[0] == (rx_level != 0)) else $error("ready flag");
  rst_clear_a: assert property (!$past(rst_n) |-> line_status == 8'h00) else $error("reset flags");
  sum_err_a: assert property (fifo_enable && |line_status[3:2] |-> line_status[7]) else $error("summary");
  oe_clr_a: assert property (status_read && !rx_char_valid |=> !line_status[1]) else $error("overrun kept");
  cover property (line_status[1]);
  cover property (rx_level == DEPTH);
  cover property (line_status[7]);
endmodule : ulsf_rx_status_chk
bind ulsf_rx_status ulsf_rx_status_chk #(.DEPTH(DEPTH)) chk_u (.*);

// *** bench/tb_ulsf_rx_status.sv ***
// Bench for the status block with DEPTH 4. Assumes the host model and checker files.
`timescale 1ns/1ps
module tb_ulsf_rx_status;
  import ulsf_pkg::*;
  logic core_clk, rst_n, fifo_enable, rx_char_valid, rbr_read, status_read;
  ulsf_char_t rx_char;
  logic [7:0] rx_data, line_status;
  logic [2:0] rx_level;
  int miscompares = 0;
  int checked = 0;
  ulsf_rx_status #(.DEPTH(4)) dut_u (.*);
  ulsf_host host_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, s, e);
    end
  endtask : chk
  task push(input logic [7:0] d, input logic f, input logic p);
    @(posedge core_clk);
    rx_char_valid <= 1'b1;
    rx_char <= '{d, f, p, 1'b0};
    @(posedge core_clk);
    rx_char_valid <= 1'b0;
    #1;
  endtask : push
  task results;
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #100us;
    miscompares++;
    results;
  end
  initial begin
    {rst_n, rx_char_valid, rx_char} = '0;
    fifo_enable = 1'b1;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(line_status, 8'h00);
    push(8'ha5, 1'b0, 1'b1);
    chk(line_status, 8'h85);
    push(8'h5a, 1'b1, 1'b0);
    chk(line_status, 8'h85);
    host_u.rd(1'b0);
    chk(line_status, 8'h89);
    host_u.rd(1'b0);
    chk(line_status, 8'h00);
    for (int i = 0; i < 5; i++) push(8'(i), 1'b0, 1'b0);
    chk(line_status, 8'h03);
    host_u.rd(1'b1);
    chk(line_status, 8'h01);
    for (int i = 0; i < 4; i++) begin
      chk(rx_data, 8'(i));
      host_u.rd(1'b0);
    end
    chk({5'h0, rx_level}, 8'h00);
    @(posedge core_clk);
    fifo_enable <= 1'b0;
    push(8'h11, 1'b0, 1'b1);
    chk(line_status, 8'h05);
    push(8'h22, 1'b1, 1'b0);
    chk(line_status, 8'h07);
    chk(rx_data, 8'h11);
    host_u.rd(1'b0);
    chk(line_status, 8'h02);
    host_u.rd(1'b1);
    chk(line_status, 8'h00);
    results;
  end
endmodule : tb_ulsf_rx_status
